// File: rtl/wit_pkg.sv
// package for the watch and interval timer
// assumes one 25 MHz system clock and a 32-bit Avalon-MM register bus

package wit_pkg;

  // ==========================================================
  // clocking and widths
  localparam int WIT_MCLK_PERIOD_NS = 40;
  localparam int WIT_DIV_W = 7;                // peripheral clock / 2^7
  localparam logic [6:0] WIT_DIV_MAX = 7'h7f;
  localparam int WIT_PRE_W = 11;               // prescaler width
  localparam int WIT_CNT_W = 5;                // watch counter width
  localparam logic [3:0] WIT_TAP_SHORT_LO = 4'h4;   // 2^4 tap
  localparam logic [3:0] WIT_TAP_SHORT_HI = 4'h5;   // 2^5 tap
  localparam logic [3:0] WIT_TAP_CNT = 4'h9;        // 2^9 tap drives the counter
  localparam logic [3:0] WIT_TAP_BASE = 4'h4;       // interval code 0 -> 2^4
  localparam logic [3:0] WIT_CNT13_MASK = 4'hf;     // 2^13 = 2^9 * 16
  localparam logic [4:0] WIT_CNT14_MASK = 5'h1f;    // 2^14 = 2^9 * 32

  // ==========================================================
  // register byte offsets
  localparam logic [4:0] WIT_OFS_MODE = 5'h00;
  localparam logic [4:0] WIT_OFS_STATUS = 5'h04;
  localparam logic [4:0] WIT_OFS_CLEAR = 5'h08;
  localparam logic [4:0] WIT_OFS_IRQ_EN = 5'h0c;
  localparam logic [4:0] WIT_OFS_COUNT = 5'h10;
  localparam int WIT_ADDR_W = 5;

  // ==========================================================
  // field layouts and reset values
  localparam logic [7:0] WIT_MODE_RESET = 8'h00;
  localparam logic [1:0] WIT_EVT_RESET = 2'h0;
  localparam logic [1:0] WIT_SEL_P14 = 2'h0;
  localparam logic [1:0] WIT_SEL_P13 = 2'h1;
  localparam logic [1:0] WIT_SEL_P5 = 2'h2;
  localparam logic [1:0] WIT_SEL_P4 = 2'h3;
  localparam int WIT_COUNT_CNT_LSB = 16;       // counter view: [20:16] counter, [10:0] prescaler

  // mode register, bit 7 down to bit 0
  typedef struct packed {
    logic clock_source_sel;
    logic [2:0] interval_sel;
    logic [1:0] watch_period_sel;
    logic counter_start_bit;
    logic timer_enable_bit;
  } wit_mode_t;

  // event group: bit 1 interval, bit 0 watch
  typedef struct packed {
    logic interval_irq;
    logic watch_irq;
  } wit_evt_t;

  // watch counter sequencing, one-hot
  typedef enum logic [2:0] {
    WIT_W_IDLE = 3'b001,
    WIT_W_FIRST = 3'b010,
    WIT_W_RUN = 3'b100
  } wit_wstate_t;

endpackage

// File: rtl/wit_prescaler.sv
// 11-bit prescaler of the watch timer
// assumes a one-cycle count tick from the parent and a synchronous clear
`timescale 1ns/1ps

module wit_prescaler #(
  parameter int WIDTH = wit_pkg::WIT_PRE_W
) (
  // clock and control
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // count control
  input wire logic clear_i,
  input wire logic tick_i,
  // count value
  output logic [WIDTH-1:0] count_o
);
  import wit_pkg::*;

  // ==========================================================
  // free counter; clear wins over the tick
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      count_o <= '0;
    end else if (ce_i) begin
      if (clear_i) begin
        count_o <= '0;
      end else if (tick_i) begin
        count_o <= count_o + 1'b1;
      end
    end
  end

endmodule

// File: rtl/wit_timer.sv
// watch and interval timer with Avalon-MM register slave
// assumes mclk_i at 25 MHz, synchronous active-low reset, sub_clk_i from a pin
//
// Behaviour
// - watch interrupt periodic while watch counting
// - clock: peripheral/128 or subsystem clock
// - watch counts only with enable and start
// - clearing both stops and clears counter
// - start low clears counter, prescaler keeps running
// - first interrupt after restart may slip 2^9
// - period select: 2^14, 2^13, 2^5, 2^4
// - interval interrupt periodic from prescaler tap
// - interval code n gives 2^(4+n)
// - interval runs only while enable is set
// - first watch interrupt late by up to 2^9
// - enable low clears prescaler and counter
// - reset clears mode register to zero
`timescale 1ns/1ps

module wit_timer (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // subsystem clock pin
  input wire logic sub_clk_i,
  // avalon-mm slave
  input wire logic [wit_pkg::WIT_ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // interrupt requests
  output wit_pkg::wit_evt_t irq_pulse_o,
  output logic irq_o
);
  import wit_pkg::*;

  // ==========================================================
  // declarations
  wit_mode_t watch_mode_reg;
  wit_evt_t status;
  wit_evt_t irq_en;
  wit_evt_t events;
  wit_wstate_t wstate;
  logic [WIT_DIV_W-1:0] div_cnt;
  logic sub_s1, sub_s2, sub_s3, sub_level;
  logic sub_edge;
  logic fw_tick;
  logic [WIT_PRE_W-1:0] pre_cnt;
  logic [WIT_CNT_W-1:0] wcnt;
  logic pre_clear;
  logic tap_cnt;
  logic watch_evt;
  logic interval_evt;
  logic bus_req;
  logic bus_write;
  logic [31:0] next_readdata;

  // ==========================================================
  // helpers
  // true when the low k bits of the prescaler are all ones
  function automatic logic tap_hit(input logic [WIT_PRE_W-1:0] pre, input logic [3:0] k);
    logic [WIT_PRE_W-1:0] mask;
    mask = WIT_PRE_W'((1 << k) - 1);
    return &(pre | ~mask);
  endfunction

  // ==========================================================
  // subsystem clock: three flops, edge once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end else if (ce_i) begin
      sub_s1 <= sub_clk_i;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  // filtered level of the subsystem clock
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sub_level <= 1'b0;
    end else if (ce_i && (sub_s2 == sub_s3)) begin
      sub_level <= sub_s3;
    end
  end

  assign sub_edge = (sub_s2 == sub_s3) && sub_s3 && !sub_level;

  // ==========================================================
  // peripheral clock divider, free running
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      div_cnt <= '0;
    end else if (ce_i) begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // watch clock tick, one cycle wide
  // limitation: the subsystem clock must be well below mclk_i / 4
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      fw_tick <= 1'b0;
    end else if (ce_i) begin
      if (watch_mode_reg.clock_source_sel) begin
        fw_tick <= sub_edge;
      end else begin
        fw_tick <= (div_cnt == WIT_DIV_MAX);
      end
    end
  end

  // ==========================================================
  // prescaler, cleared only by the enable bit
  assign pre_clear = !watch_mode_reg.timer_enable_bit;

  wit_prescaler #(
    .WIDTH(WIT_PRE_W)
  ) u_pre (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .clear_i(pre_clear),
    .tick_i(fw_tick),
    .count_o(pre_cnt)
  );

  assign tap_cnt = fw_tick && tap_hit(pre_cnt, WIT_TAP_CNT);

  // ==========================================================
  // watch counter sequencing
  // the first 2^9 tap after start only arms the counter, hence the late first interrupt
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      wstate <= WIT_W_IDLE;
    end else if (ce_i) begin
      case (wstate)
        WIT_W_IDLE: begin
          if (watch_mode_reg.timer_enable_bit && watch_mode_reg.counter_start_bit) begin
            wstate <= WIT_W_FIRST;
          end
        end
        WIT_W_FIRST: begin
          if (!(watch_mode_reg.timer_enable_bit && watch_mode_reg.counter_start_bit)) begin
            wstate <= WIT_W_IDLE;
          end else if (tap_cnt) begin
            wstate <= WIT_W_RUN;
          end
        end
        WIT_W_RUN: begin
          if (!(watch_mode_reg.timer_enable_bit && watch_mode_reg.counter_start_bit)) begin
            wstate <= WIT_W_IDLE;
          end
        end
        default: begin
          wstate <= WIT_W_IDLE;
        end
      endcase
    end
  end

  // 5-bit counter: cleared whenever watch counting is off
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      wcnt <= '0;
    end else if (ce_i) begin
      if (wstate != WIT_W_RUN || !watch_mode_reg.counter_start_bit
          || !watch_mode_reg.timer_enable_bit) begin
        wcnt <= '0;
      end else if (tap_cnt) begin
        wcnt <= wcnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // event decode
  // restart keeps the prescaler phase, so the first period may slip up to 2^9
  always_comb begin
    watch_evt = 1'b0;
    if (wstate == WIT_W_RUN && watch_mode_reg.counter_start_bit
        && watch_mode_reg.timer_enable_bit) begin
      case (watch_mode_reg.watch_period_sel)
        WIT_SEL_P14: watch_evt = tap_cnt && (wcnt == WIT_CNT14_MASK);
        WIT_SEL_P13: watch_evt = tap_cnt && (wcnt[3:0] == WIT_CNT13_MASK);
        WIT_SEL_P5: watch_evt = fw_tick && tap_hit(pre_cnt, WIT_TAP_SHORT_HI);
        WIT_SEL_P4: watch_evt = fw_tick && tap_hit(pre_cnt, WIT_TAP_SHORT_LO);
        default: watch_evt = 1'b0;
      endcase
    end
  end

  // interval tap: base tap plus the three-bit code
  assign interval_evt = watch_mode_reg.timer_enable_bit && fw_tick
    && tap_hit(pre_cnt, WIT_TAP_BASE + {1'b0, watch_mode_reg.interval_sel});

  assign events = '{interval_irq: interval_evt, watch_irq: watch_evt};

  // one-cycle request pulses
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_pulse_o <= WIT_EVT_RESET;
    end else if (ce_i) begin
      irq_pulse_o <= events;
    end
  end

  // ==========================================================
  // avalon-mm slave: one wait cycle, then the access completes
  assign bus_req = read_i || write_i;
  assign bus_write = write_i && !waitrequest_o && byteenable_i[0];

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      waitrequest_o <= !(bus_req && waitrequest_o);
    end
  end

  // read mux; unmapped offsets and the clear register read zero
  always_comb begin
    next_readdata = '0;
    case (address_i)
      WIT_OFS_MODE: next_readdata = {24'h0000_00, watch_mode_reg};
      WIT_OFS_STATUS: next_readdata = {30'h000_0000, status};
      WIT_OFS_IRQ_EN: next_readdata = {30'h000_0000, irq_en};
      WIT_OFS_COUNT: begin
        next_readdata[WIT_PRE_W-1:0] = pre_cnt;
        next_readdata[WIT_COUNT_CNT_LSB +: WIT_CNT_W] = wcnt;
      end
      default: next_readdata = '0;
    endcase
  end

  // read data captured while waitrequest is still high
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      readdata_o <= '0;
    end else if (ce_i && read_i && waitrequest_o) begin
      readdata_o <= next_readdata;
    end
  end

  // mode register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      watch_mode_reg <= WIT_MODE_RESET;
    end else if (ce_i && bus_write && address_i == WIT_OFS_MODE) begin
      watch_mode_reg <= writedata_i[7:0];
    end
  end

  // interrupt enable register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_en <= WIT_EVT_RESET;
    end else if (ce_i && bus_write && address_i == WIT_OFS_IRQ_EN) begin
      irq_en <= writedata_i[1:0];
    end
  end

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      status <= WIT_EVT_RESET;
    end else if (ce_i) begin
      if (bus_write && address_i == WIT_OFS_CLEAR) begin
        status <= (status & ~writedata_i[1:0]) | events;
      end else begin
        status <= status | events;
      end
    end
  end

  // level interrupt from a flop
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status & irq_en);
    end
  end

  // ==========================================================
  // checks
  sequence s_watch_begin;
    ce_i && wstate == WIT_W_IDLE && watch_mode_reg.timer_enable_bit
      && watch_mode_reg.counter_start_bit;
  endsequence

  sequence s_armed;
    wstate == WIT_W_FIRST;
  endsequence

  property p_begin_arms;
    @(posedge mclk_i) disable iff (!resetn_i)
      s_watch_begin |=> s_armed;
  endproperty
  a_begin_arms: assert property (p_begin_arms) else $error("watch start not armed");

  property p_first_late;
    @(posedge mclk_i) disable iff (!resetn_i)
      s_armed |-> !watch_evt;
  endproperty
  a_first_late: assert property (p_first_late) else $error("watch event while arming");

  property p_stop_clears;
    @(posedge mclk_i) disable iff (!resetn_i)
      ce_i && !watch_mode_reg.timer_enable_bit |=> pre_cnt == '0 && wcnt == '0;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear");

  property p_restart_keeps_pre;
    @(posedge mclk_i) disable iff (!resetn_i)
      ce_i && watch_mode_reg.timer_enable_bit && !watch_mode_reg.counter_start_bit
        && !fw_tick |=> wcnt == '0 && pre_cnt == $past(pre_cnt);
  endproperty
  a_restart_keeps_pre: assert property (p_restart_keeps_pre) else $error("restart hit prescaler");

  property p_interval_gate;
    @(posedge mclk_i) disable iff (!resetn_i)
      interval_evt |-> watch_mode_reg.timer_enable_bit && pre_cnt[3:0] == 4'hf;
  endproperty
  a_interval_gate: assert property (p_interval_gate) else $error("interval event misplaced");

  property p_long_from_cnt;
    @(posedge mclk_i) disable iff (!resetn_i)
      watch_evt && !watch_mode_reg.watch_period_sel[1] |-> tap_cnt && wcnt[3:0] == 4'hf;
  endproperty
  a_long_from_cnt: assert property (p_long_from_cnt) else $error("long period not from counter");

  property p_pulse_one;
    @(posedge mclk_i) disable iff (!resetn_i)
      ce_i && events != '0 |=> irq_pulse_o == $past(events) ##1 (!ce_i || irq_pulse_o != $past(irq_pulse_o) || events == irq_pulse_o);
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("request pulse wrong");

  property p_div_tick;
    @(posedge mclk_i) disable iff (!resetn_i)
      ce_i && !watch_mode_reg.clock_source_sel && div_cnt == WIT_DIV_MAX |=> fw_tick;
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("divided clock tick missing");

  property p_reset_mode;
    @(posedge mclk_i) !resetn_i |=> watch_mode_reg == WIT_MODE_RESET;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not cleared by reset");

  property p_irq_level;
    @(posedge mclk_i) disable iff (!resetn_i)
      ce_i && (status & irq_en) != '0 |=> irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level missing");

endmodule

// File: test/test_wit_timer.sv
// self-checking testbench for the watch and interval timer
// assumes wit_pkg and wit_timer are compiled first; the bench drives every port itself
`timescale 1ns/1ps

module test_wit_timer;
  import wit_pkg::*;

  // ==========================================================
  // signals and design
  localparam int FW = 6;          // sub clock period in mclk cycles
  localparam int LIMIT = 100000;  // whole run is about 76k cycles
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic sub_clk_i = 1'b0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [4:0] address_i = 5'h00;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [3:0] byteenable_i = 4'h0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic irq_o;
  wit_evt_t irq_pulse_o;
  wit_evt_t prev = 2'h0;
  logic [31:0] rd;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int wn = 0;
  int inn = 0;
  int t0, t1, t2, s0, s1;

  wit_timer dut (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .sub_clk_i(sub_clk_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .writedata_i(writedata_i),
    .byteenable_i(byteenable_i),
    .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o),
    .irq_pulse_o(irq_pulse_o),
    .irq_o(irq_o)
  );

`define CHK(g, e) check(32'(g), 32'(e))

  // ==========================================================
  // clock, sub clock and event monitor
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  // sub clock locked to mclk so tick spacing is exact and periods can be compared exactly
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    prev <= irq_pulse_o;
    if (cyc % 3 == 2) begin
      sub_clk_i <= ~sub_clk_i;
    end
    if (irq_pulse_o.watch_irq === 1'b1) begin
      wn++;
      `CHK(prev.watch_irq, 0);
    end
    if (irq_pulse_o.interval_irq === 1'b1) begin
      inn++;
      `CHK(prev.interval_irq, 0);
    end
    if (cyc >= LIMIT) begin
      failures++;
      report_and_stop();
    end
  end

  // ==========================================================
  // tasks
  task check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    write_i <= wr;
    read_i <= !wr;
    @(posedge mclk_i);
    // only the global cycle limit ends a wait for the slave
    while (waitrequest_o !== 1'b0) begin
      @(posedge mclk_i);
    end
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    `CHK(rd, e);
  endtask

  // next pulse on bit b after the current edge, bounded
  task wait_pulse(input int b, output int t);
    int n;
    n = 0;
    @(posedge mclk_i);
    while (irq_pulse_o[b] !== 1'b1 && n < 20000) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK(irq_pulse_o[b], 1);
    t = cyc;
  endtask

  task period(input int b, input int e);
    wait_pulse(b, t1);
    wait_pulse(b, t2);
    `CHK(t2 - t1, e);
  endtask

  task report_and_stop();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    // reset state and an unmapped place
    rdchk(WIT_OFS_MODE, 32'h0000_0000);
    rdchk(WIT_OFS_STATUS, 32'h0000_0000);
    rdchk(WIT_OFS_COUNT, 32'h0000_0000);
    `CHK(irq_o, 0);
    wr(5'h14, 32'h0000_00ff);
    rdchk(5'h14, 32'h0000_0000);
    // every interval code on the sub clock, enable only, so no watch events
    for (int n = 0; n < 8; n++) begin
      wr(WIT_OFS_MODE, 32'h0000_0080);
      wr(WIT_OFS_MODE, 32'h0000_0081 | (n << 4));
      period(1, (16 << n) * FW);
    end
    `CHK(wn, 0);
    // peripheral clock divided by 128
    wr(WIT_OFS_MODE, 32'h0000_0000);
    wr(WIT_OFS_MODE, 32'h0000_0001);
    period(1, 16 * 128);
    // short watch periods: first event late by up to the arming tap, then exact
    for (int p = 4; p <= 5; p++) begin
      wr(WIT_OFS_MODE, 32'h0000_0080);
      wr(WIT_OFS_MODE, (p == 4) ? 32'h0000_008f : 32'h0000_008b);
      t0 = cyc;
      wait_pulse(0, t1);
      `CHK(t1 - t0 >= (1 << p) * FW && t1 - t0 <= ((1 << p) + 512) * FW + 16, 1);
      period(0, (1 << p) * FW);
    end
    // zero-second restart: counter cleared, prescaler and interval keep going
    wr(WIT_OFS_MODE, 32'h0000_008d);
    t0 = cyc;
    bus(1'b0, WIT_OFS_COUNT, 32'h0000_0000, 4'hf);
    `CHK(rd[20:16], 0);
    s0 = rd[10:0];
    wait_pulse(1, t1);
    `CHK(t1 - t0 <= 16 * FW + 8, 1);
    bus(1'b0, WIT_OFS_COUNT, 32'h0000_0000, 4'hf);
    `CHK(rd[10:0] != s0, 1);
    wr(WIT_OFS_MODE, 32'h0000_008f);
    t0 = cyc;
    wait_pulse(0, t1);
    `CHK(t1 - t0 <= (16 + 512) * FW + 16, 1);
    period(0, 16 * FW);
    // sticky status, level interrupt, mask, refused byte lane
    rdchk(WIT_OFS_STATUS, 32'h0000_0003);
    wr(WIT_OFS_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge mclk_i);
    `CHK(irq_o, 1);
    bus(1'b1, WIT_OFS_IRQ_EN, 32'h0000_0000, 4'h0);
    rdchk(WIT_OFS_IRQ_EN, 32'h0000_0001);
    wr(WIT_OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge mclk_i);
    `CHK(irq_o, 0);
    // long periods: counter steps once per 2^9 ticks, no watch event yet
    wr(WIT_OFS_MODE, 32'h0000_0080);
    wr(WIT_OFS_MODE, 32'h0000_00f7);
    s0 = wn;
    repeat (1280 * FW) @(posedge mclk_i);
    bus(1'b0, WIT_OFS_COUNT, 32'h0000_0000, 4'hf);
    `CHK(rd[20:16], 1);
    wr(WIT_OFS_MODE, 32'h0000_00f3);
    repeat (512 * FW) @(posedge mclk_i);
    bus(1'b0, WIT_OFS_COUNT, 32'h0000_0000, 4'hf);
    `CHK(rd[20:16], 2);
    `CHK(wn, s0);
    // clock enable low freezes the prescaler; the 2^11 interval keeps pulses out of the freeze
    s1 = rd[10:0];
    ce_i <= 1'b0;
    repeat (200) @(posedge mclk_i);
    ce_i <= 1'b1;
    bus(1'b0, WIT_OFS_COUNT, 32'h0000_0000, 4'hf);
    `CHK(11'(rd[10:0] - s1[10:0]) <= 2, 1);
    // stop: both counts cleared and silent, then clear the status
    wr(WIT_OFS_MODE, 32'h0000_0080);
    rdchk(WIT_OFS_COUNT, 32'h0000_0000);
    // pulses launched before the stop have drained by now
    s0 = wn;
    s1 = inn;
    wr(WIT_OFS_CLEAR, 32'h0000_0003);
    rdchk(WIT_OFS_STATUS, 32'h0000_0000);
    repeat (1200) @(posedge mclk_i);
    `CHK(wn == s0 && inn == s1, 1);
    // reset in mid-run clears the registers again
    wr(WIT_OFS_IRQ_EN, 32'h0000_0003);
    resetn_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rdchk(WIT_OFS_MODE, 32'h0000_0000);
    rdchk(WIT_OFS_IRQ_EN, 32'h0000_0000);
    report_and_stop();
  end
endmodule
